// >>> rtl/qdcc_pkg.sv
// constants and types shared by the quad converter config/control block
package qdcc_pkg;

	// register byte offsets on the local bus
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h20;

	// configuration register field positions
	localparam int CFG_RANGE_A_LSB = 0;
	localparam int CFG_RANGE_B_LSB = 3;
	localparam int CFG_RANGE_C_LSB = 6;
	localparam int CFG_RANGE_D_LSB = 9;
	localparam int CFG_CLEAR_DEFAULT_SELECT_BIT = 13;
	localparam int CFG_CLAMP_BIT = 14;
	localparam int CFG_THERM_BIT = 15;
	localparam int CFG_PWRUP_LSB = 16;

	// control register field positions
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_LOAD_IRQ_BIT = 3;
	localparam int CTL_ALERT_IRQ_BIT = 4;
	localparam int CTL_SEQ_IRQ_BIT = 5;
	localparam int CTL_ASR_BIT = 7;
	localparam int CTL_GLM_BIT = 8;
	localparam int CTL_RDREQ_BIT = 9;

	// output range codes
	localparam logic [2:0] RANGE_UNI_5V = 3'h0;
	localparam logic [2:0] RANGE_UNI_10V = 3'h1;
	localparam logic [2:0] RANGE_UNI_10V8 = 3'h2;
	localparam logic [2:0] RANGE_BIP_5V = 3'h3;
	localparam logic [2:0] RANGE_BIP_10V = 3'h4;
	localparam logic [2:0] RANGE_BIP_10V8 = 3'h5;

	// converter modes
	localparam logic [2:0] MODE_INSTANT = 3'h0;
	localparam logic [2:0] MODE_MANUAL = 3'h1;
	localparam logic [2:0] MODE_TIMER = 3'h3;

	// reset values
	localparam logic [2:0] RANGE_RST = 3'h0;
	localparam logic CLAMP_RST = 1'b1;

	// status read delay after a timer-mode update
	localparam int CLK_PERIOD_NS = 50;
	localparam int AUTO_RD_DELAY_NS = 10000;
	localparam int AUTO_RD_DELAY_CYC = AUTO_RD_DELAY_NS / CLK_PERIOD_NS;

	// configuration register image
	typedef struct packed {
		logic [3:0] pwrup;	// channel power-up d..a
		logic therm_ena;	// thermal shutdown enable
		logic clamp_ena;	// current clamp enable
		logic clear_default_select;	// clear default select
		logic [2:0] range_d;	// channel d output range
		logic [2:0] range_c;	// channel c output range
		logic [2:0] range_b;	// channel b output range
		logic [2:0] range_a;	// channel a output range
	} qdcc_cfg_t;

	// control register image (request bit is never stored)
	typedef struct packed {
		logic global_load_enable;
		logic auto_status_read_enable;
		logic sequencer_irq_enable;
		logic alert_irq_enable;
		logic load_irq_enable;
		logic [2:0] mode;
	} qdcc_ctl_t;

	// interrupt sources of one converter
	typedef struct packed {
		logic seq;
		logic alert;
		logic load;
	} qdcc_irq_t;

endpackage

// >>> rtl/qdcc_delay.sv
// one-shot delay: pulses once a fixed number of cycles after a start pulse
`timescale 1ns/100ps
module qdcc_delay import qdcc_pkg::*; #(
	parameter int DELAY_CYC = AUTO_RD_DELAY_CYC
) (
	input wire logic clk_sys,	// system clock
	input wire logic rstn,	// async reset, active low
	input wire logic start,	// begin (or restart) the delay
	input wire logic cancel,	// abandon a running delay
	output logic fire_ff	// one-cycle pulse at expiry
);

	localparam int CW = $clog2(DELAY_CYC + 1);

	// refuse a delay that the countdown cannot serve
	if (DELAY_CYC < 1) begin : g_bad_delay
		$error("qdcc_delay: DELAY_CYC must be at least 1");
	end

	logic [CW-1:0] cnt_ff;
	logic run_ff;

	////////////////////////////////////////////////////////////////////////
	// countdown; a restart rearms so only one pulse comes per start
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
			fire_ff <= 1'b0;
		end else begin
			fire_ff <= 1'b0;
			if (start) begin
				cnt_ff <= CW'(DELAY_CYC - 1);
				run_ff <= 1'b1;
			end else if (cancel) begin
				run_ff <= 1'b0;
			end else if (run_ff) begin
				if (cnt_ff == '0) begin
					run_ff <= 1'b0;
					fire_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff - 1'b1;
				end
			end
		end
	end

endmodule

// >>> rtl/qdcc_regs.sv
// configuration and control registers of one quad converter
//
// What this block does
// [R1] bit 13 picks the clear default level
// [R2] software writes zero to reserved bits
// [R3] four 3-bit range fields, reset 000
// [R4] range codes 000..101, rest reserved
// [R5] status request write-only, instant/manual only
// [R6] request logs pending, clears valid flag
// [R7] request self-clears; read may wait, kept
// [R8] global load: update with all global converters
// [R9] standalone: update when own data done
// [R10] auto status reads paced by timer
// [R11] timer mode: one read ~10us after update
// [R12] sequencer interrupt gated by its enable
// [R13] alert interrupt gated by its enable
// [R14] load interrupt gated by its enable
// [R15] config writes while busy are discarded
// [R16] mode codes; instant updates per transfer
// [R17] valid set after first status read
// [R18] enables gate sources, other bits untouched
`timescale 1ns/100ps
module qdcc_regs import qdcc_pkg::*; #(
	parameter int DELAY_CYC = AUTO_RD_DELAY_CYC
) (
	input wire logic clk_sys,	// system clock, 20 MHz
	input wire logic rstn,	// async reset, active low
	input wire logic lb_cs,	// local bus select
	input wire logic lb_wr,	// write strobe
	input wire logic lb_rd,	// read strobe
	input wire logic [7:0] lb_addr,	// byte address
	input wire logic [31:0] lb_wdata,	// write data
	output logic [31:0] lb_rdata_ff,	// read data
	output logic lb_ack_ff,	// access done pulse
	input wire logic conv_ops_busy,	// converter link busy with other work
	input wire logic stat_rd_done,	// status read finished pulse
	input wire logic chan_xfer_done,	// one channel transferred pulse
	input wire logic own_xfer_done,	// all data sent to this converter
	input wire logic glob_xfer_done,	// all data sent to global converters
	input wire logic seq_update,	// sequencer timer update pulse
	input wire logic auto_tmr_tick,	// auto status timer tick
	input qdcc_irq_t irq_src,	// raw interrupt events
	output qdcc_cfg_t cfg_ff,	// stored configuration
	output logic cfg_start_ff,	// start config transfer pulse
	output logic stat_rd_start_ff,	// start status read pulse
	output logic update_ff,	// output update pulse
	output logic busy_ff,	// configuration in progress
	output logic status_valid_flag_ff,	// status register valid
	output qdcc_irq_t irq_ff,	// gated interrupt pulses
	output logic [2:0] mode_ff,	// converter mode
	output logic global_load_enable_ff	// joins global update
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_READ = 2'b10
	} qdcc_rd_st_t;

	qdcc_ctl_t ctl_ff;
	qdcc_rd_st_t rd_st_ff;
	qdcc_rd_st_t nxt_rd_st;
	logic req_pend_ff;
	logic rd_is_cfg_ff;
	logic cfg_pend_ff;
	logic cfg_go;
	logic wr_cfg;
	logic wr_ctl;
	logic rd_req_wr;
	logic inst_or_man;
	logic auto_fire;
	logic launch;

	// true when this mode honours manual status requests
	function automatic logic mode_im(input logic [2:0] m);
		return (m == MODE_INSTANT) || (m == MODE_MANUAL);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// address decode; the bus always moves whole words
	assign wr_cfg = lb_cs && lb_wr && (lb_addr == OFS_CONFIG);
	assign wr_ctl = lb_cs && lb_wr && (lb_addr == OFS_CONTROL);
	assign inst_or_man = mode_im(ctl_ff.mode);
	assign rd_req_wr = wr_ctl && lb_wdata[CTL_RDREQ_BIT] && inst_or_man;	// [R5]

	// a configuration accepted while a requested read is in flight waits for
	// the shared read sequencer, otherwise its closing read would be lost
	assign cfg_go = ((wr_cfg && !busy_ff) || cfg_pend_ff) && (rd_st_ff == ST_IDLE);

	////////////////////////////////////////////////////////////////////////
	// configuration register; a write while busy is dropped
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_ff.pwrup <= 4'h0;
			cfg_ff.therm_ena <= 1'b0;
			cfg_ff.clamp_ena <= CLAMP_RST;
			cfg_ff.clear_default_select <= 1'b0;	// [R1]
			cfg_ff.range_d <= RANGE_RST;	// [R3]
			cfg_ff.range_c <= RANGE_RST;
			cfg_ff.range_b <= RANGE_RST;
			cfg_ff.range_a <= RANGE_RST;
		end else if (wr_cfg && !busy_ff) begin	// [R15]
			cfg_ff.pwrup <= lb_wdata[CFG_PWRUP_LSB +: 4];
			cfg_ff.therm_ena <= lb_wdata[CFG_THERM_BIT];
			cfg_ff.clamp_ena <= lb_wdata[CFG_CLAMP_BIT];
			cfg_ff.clear_default_select <= lb_wdata[CFG_CLEAR_DEFAULT_SELECT_BIT];	// [R1]
			cfg_ff.range_d <= lb_wdata[CFG_RANGE_D_LSB +: 3];	// [R3] [R4]
			cfg_ff.range_c <= lb_wdata[CFG_RANGE_C_LSB +: 3];
			cfg_ff.range_b <= lb_wdata[CFG_RANGE_B_LSB +: 3];
			cfg_ff.range_a <= lb_wdata[CFG_RANGE_A_LSB +: 3];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register; bit 9, bit 6 and the high bits are not stored
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctl_ff <= '0;
		end else if (wr_ctl) begin	// [R18]
			ctl_ff.global_load_enable <= lb_wdata[CTL_GLM_BIT];	// [R8] [R9]
			ctl_ff.auto_status_read_enable <= lb_wdata[CTL_ASR_BIT];	// [R10]
			ctl_ff.sequencer_irq_enable <= lb_wdata[CTL_SEQ_IRQ_BIT];
			ctl_ff.alert_irq_enable <= lb_wdata[CTL_ALERT_IRQ_BIT];
			ctl_ff.load_irq_enable <= lb_wdata[CTL_LOAD_IRQ_BIT];
			ctl_ff.mode <= lb_wdata[CTL_MODE_LSB +: 3];	// [R16]
		end
	end

	// mode and global-load flag go out for the channel data paths
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_ff <= MODE_INSTANT;
			global_load_enable_ff <= 1'b0;
		end else begin
			mode_ff <= ctl_ff.mode;
			global_load_enable_ff <= ctl_ff.global_load_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus answer; reserved bits and unmapped reads return zero,
	// the request bit always reads as zero because it is never stored
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lb_rdata_ff <= 32'h0;
			lb_ack_ff <= 1'b0;
		end else begin
			lb_ack_ff <= lb_cs && (lb_wr || lb_rd);
			lb_rdata_ff <= 32'h0;
			if (lb_cs && lb_rd) begin
				if (lb_addr == OFS_CONFIG) begin
					lb_rdata_ff[CFG_PWRUP_LSB +: 4] <= cfg_ff.pwrup;
					lb_rdata_ff[CFG_THERM_BIT] <= cfg_ff.therm_ena;
					lb_rdata_ff[CFG_CLAMP_BIT] <= cfg_ff.clamp_ena;
					lb_rdata_ff[CFG_CLEAR_DEFAULT_SELECT_BIT] <= cfg_ff.clear_default_select;
					lb_rdata_ff[CFG_RANGE_D_LSB +: 3] <= cfg_ff.range_d;
					lb_rdata_ff[CFG_RANGE_C_LSB +: 3] <= cfg_ff.range_c;
					lb_rdata_ff[CFG_RANGE_B_LSB +: 3] <= cfg_ff.range_b;
					lb_rdata_ff[CFG_RANGE_A_LSB +: 3] <= cfg_ff.range_a;
				end else if (lb_addr == OFS_CONTROL) begin
					lb_rdata_ff[CTL_GLM_BIT] <= ctl_ff.global_load_enable;
					lb_rdata_ff[CTL_ASR_BIT] <= ctl_ff.auto_status_read_enable;
					lb_rdata_ff[CTL_SEQ_IRQ_BIT] <= ctl_ff.sequencer_irq_enable;
					lb_rdata_ff[CTL_ALERT_IRQ_BIT] <= ctl_ff.alert_irq_enable;
					lb_rdata_ff[CTL_LOAD_IRQ_BIT] <= ctl_ff.load_irq_enable;
					lb_rdata_ff[CTL_MODE_LSB +: 3] <= ctl_ff.mode;	// [R5]
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration start and busy; busy covers the status read that
	// every configuration sequence ends with
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_start_ff <= 1'b0;
			cfg_pend_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			cfg_start_ff <= cfg_go;	// [R15]
			if (wr_cfg && !busy_ff && rd_st_ff != ST_IDLE)
				cfg_pend_ff <= 1'b1;
			else if (rd_st_ff == ST_IDLE)
				cfg_pend_ff <= 1'b0;
			if (wr_cfg && !busy_ff)
				busy_ff <= 1'b1;
			else if (rd_st_ff == ST_READ && rd_is_cfg_ff && stat_rd_done)
				busy_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output update timing per mode
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			update_ff <= 1'b0;
		end else begin
			unique case (ctl_ff.mode)
				MODE_INSTANT: update_ff <= chan_xfer_done;	// [R16]
				MODE_MANUAL: begin
					if (ctl_ff.global_load_enable)
						update_ff <= glob_xfer_done;	// [R8]
					else
						update_ff <= own_xfer_done;	// [R9]
				end
				MODE_TIMER: update_ff <= seq_update;
				default: update_ff <= 1'b0;	// reserved codes never update
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timer mode: one status read a fixed time after each update; a new
	// update restarts the wait, so a sequence never yields two reads
	qdcc_delay #(
		.DELAY_CYC(DELAY_CYC)
	) u_delay (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.start(update_ff && (ctl_ff.mode == MODE_TIMER)
			&& ctl_ff.auto_status_read_enable),	// [R11]
		.cancel(!ctl_ff.auto_status_read_enable
			|| (ctl_ff.mode != MODE_TIMER)),
		.fire_ff(auto_fire)
	);

	////////////////////////////////////////////////////////////////////////
	// pending status read; held until the link is free so no request
	// is lost, a request already pending simply merges
	// a configuration write takes the sequencer first; the request just waits
	assign launch = req_pend_ff && (rd_st_ff == ST_IDLE) && !conv_ops_busy
		&& !busy_ff && !wr_cfg;	// [R7]

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			req_pend_ff <= 1'b0;
		end else begin
			if (rd_req_wr)	// [R6]
				req_pend_ff <= 1'b1;
			else if (ctl_ff.auto_status_read_enable && inst_or_man && auto_tmr_tick)
				req_pend_ff <= 1'b1;	// [R10]
			else if (auto_fire)
				req_pend_ff <= 1'b1;	// [R11]
			else if (launch)
				req_pend_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status read sequencer; config reads and requested reads share it
	always_comb begin
		nxt_rd_st = rd_st_ff;
		unique case (rd_st_ff)
			ST_IDLE: begin
				if (launch || cfg_start_ff)
					nxt_rd_st = ST_READ;
			end
			ST_READ: begin
				if (stat_rd_done)
					nxt_rd_st = ST_IDLE;
			end
			default: nxt_rd_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rd_st_ff <= ST_IDLE;
		end else begin
			rd_st_ff <= nxt_rd_st;
		end
	end

	// remember whether the read in flight belongs to a configuration
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rd_is_cfg_ff <= 1'b0;
			stat_rd_start_ff <= 1'b0;
		end else begin
			stat_rd_start_ff <= launch;	// [R7]
			if (rd_st_ff == ST_IDLE && cfg_start_ff)
				rd_is_cfg_ff <= 1'b1;
			else if (rd_st_ff == ST_IDLE && launch)
				rd_is_cfg_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status valid: set by any finished read, cleared by a new request;
	// a finish in the same cycle as a request wins
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			status_valid_flag_ff <= 1'b0;
		end else begin
			if (rd_st_ff == ST_READ && stat_rd_done)
				status_valid_flag_ff <= 1'b1;	// [R17] [R6]
			else if (rd_req_wr)
				status_valid_flag_ff <= 1'b0;	// [R6]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt gating; each source passes only with its own enable
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_ff <= '0;
		end else begin
			irq_ff.seq <= irq_src.seq && ctl_ff.sequencer_irq_enable;	// [R12] [R18]
			irq_ff.alert <= irq_src.alert && ctl_ff.alert_irq_enable;	// [R13]
			irq_ff.load <= irq_src.load && ctl_ff.load_irq_enable;	// [R14]
		end
	end

endmodule

// >>> dv/qdcc_monitor.sv
// assertion checker for the converter config/control registers
`timescale 1ns/100ps
module qdcc_monitor import qdcc_pkg::*; (
	input wire logic clk_sys,	// clock
	input wire logic rstn,	// reset
	input wire logic lb_cs,	// select
	input wire logic lb_wr,	// write strobe
	input wire logic lb_rd,	// read strobe
	input wire logic [7:0] lb_addr,	// address
	input wire logic [31:0] lb_wdata,	// write data
	input wire logic [31:0] lb_rdata_ff,	// read data
	input wire logic stat_rd_done,	// read done
	input wire logic stat_rd_start_ff,	// requested read start
	input wire logic own_xfer_done,	// own data sent
	input wire logic glob_xfer_done,	// global data sent
	input qdcc_irq_t irq_src,	// raw events
	input qdcc_cfg_t cfg_ff,	// configuration
	input wire logic cfg_start_ff,	// config start
	input wire logic update_ff,	// output update
	input wire logic busy_ff,	// busy
	input wire logic status_valid_flag_ff,	// status valid
	input qdcc_irq_t irq_ff,	// gated events
	input wire logic [2:0] mode_ff,	// mode
	input wire logic global_load_enable_ff	// global load
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic [2:0] en_ff;
	logic rd_fly_ff;

	// a requested read is in flight from its start pulse to its done pulse
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rd_fly_ff <= 1'b0;
		end else if (stat_rd_start_ff) begin
			rd_fly_ff <= 1'b1;
		end else if (stat_rd_done) begin
			rd_fly_ff <= 1'b0;
		end
	end

	// shadow of the three enables, {seq,alert,load}, to judge gating
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			en_ff <= 3'h0;
		end else if (lb_cs && lb_wr && lb_addr == OFS_CONTROL) begin
			en_ff <= lb_wdata[5:3];
		end
	end

	////////////////////////////////////////////////////////////
	// a request right after a control write would see a stale mode copy
	sequence s_cfg_wr; lb_cs && lb_wr && lb_addr == OFS_CONFIG; endsequence
	sequence s_req;
		lb_cs && lb_wr && lb_addr == OFS_CONTROL && lb_wdata[9] && !$past(lb_wr) && !stat_rd_done;
	endsequence
	property p_cfg_busy; s_cfg_wr ##0 busy_ff |=> !cfg_start_ff && $stable(cfg_ff); endproperty
	a_cfg_busy: assert property (p_cfg_busy) else $error("config taken while busy");
	property p_cfg_take;
		s_cfg_wr ##0 !busy_ff |=> busy_ff
			&& cfg_ff == qdcc_cfg_t'({$past(lb_wdata[19:13]), $past(lb_wdata[11:0])});
	endproperty
	a_cfg_take: assert property (p_cfg_take) else $error("config write not applied");
	property p_cfg_start;
		s_cfg_wr ##0 !busy_ff && !stat_rd_start_ff && !rd_fly_ff |=> cfg_start_ff;
	endproperty
	a_cfg_start: assert property (p_cfg_start) else $error("config start missing");
	property p_req; s_req ##0 mode_ff <= MODE_MANUAL |=> !status_valid_flag_ff; endproperty
	a_req: assert property (p_req) else $error("request left valid set");
	property p_req_ign;
		s_req ##0 mode_ff == MODE_TIMER && status_valid_flag_ff |=> status_valid_flag_ff;
	endproperty
	a_req_ign: assert property (p_req_ign) else $error("timer mode request acted on");
	property p_rd_ctl; lb_cs && lb_rd && lb_addr == OFS_CONTROL |=> lb_rdata_ff[31:9] == 23'h0; endproperty
	a_rd_ctl: assert property (p_rd_ctl) else $error("control read shows upper bits");
	property p_irq_seq; irq_src.seq |=> irq_ff.seq == $past(en_ff[2]); endproperty
	a_irq_seq: assert property (p_irq_seq) else $error("sequencer irq gating wrong");
	property p_irq_alert; irq_src.alert |=> irq_ff.alert == $past(en_ff[1]); endproperty
	a_irq_alert: assert property (p_irq_alert) else $error("alert irq gating wrong");
	property p_irq_load; irq_src.load |=> irq_ff.load == $past(en_ff[0]); endproperty
	a_irq_load: assert property (p_irq_load) else $error("load irq gating wrong");
	property p_upd_glob;
		glob_xfer_done && mode_ff == MODE_MANUAL && global_load_enable_ff |=> update_ff;
	endproperty
	a_upd_glob: assert property (p_upd_glob) else $error("no global update");
	property p_upd_own;
		own_xfer_done && mode_ff == MODE_MANUAL && !global_load_enable_ff |=> update_ff;
	endproperty
	a_upd_own: assert property (p_upd_own) else $error("no standalone update");
endmodule

bind qdcc_regs qdcc_monitor qdcc_monitor_i (.clk_sys, .rstn, .lb_cs, .lb_wr, .lb_rd, .lb_addr,
	.lb_wdata, .lb_rdata_ff, .stat_rd_done, .stat_rd_start_ff, .own_xfer_done, .glob_xfer_done,
	.irq_src, .cfg_ff,
	.cfg_start_ff, .update_ff, .busy_ff, .status_valid_flag_ff, .irq_ff, .mode_ff,
	.global_load_enable_ff);

// >>> dv/qdcc_conv_model.sv
// behavioural converter on the far side: answers status reads
`timescale 1ns/100ps
module qdcc_conv_model (
	input wire logic clk_sys,	// clock
	input wire logic rstn,	// reset
	input wire logic rd_go,	// read start pulse
	input wire logic [3:0] lat,	// answer delay, cycles
	input wire logic hold,	// other work on the link
	output logic done,	// read finished pulse
	output logic link_busy	// link occupied
);
	logic run_ff;
	logic [3:0] cnt_ff;

	// one read at a time; a start while running is dropped like a real link
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			run_ff <= 1'b0;
			cnt_ff <= 4'h0;
			done <= 1'b0;
		end else begin
			done <= run_ff && cnt_ff == 4'h0;
			if (!run_ff && rd_go) begin
				run_ff <= 1'b1;
				cnt_ff <= lat;
			end else if (run_ff && cnt_ff == 4'h0) begin
				run_ff <= 1'b0;
			end else if (run_ff) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
		end
	end
	assign link_busy = hold | run_ff;
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the converter config/control registers
`timescale 1ns/100ps
module tb_top import qdcc_pkg::*; ();
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic lb_cs = 1'b0;
	logic lb_wr = 1'b0;
	logic lb_rd = 1'b0;
	logic [7:0] lb_addr = 8'h00;
	logic [31:0] lb_wdata = 32'h0;
	logic [7:0] ev = 8'h00;
	logic hold = 1'b0;
	logic [3:0] lat = 4'h9;
	logic [31:0] lb_rdata_ff, rv;
	logic lb_ack_ff, conv_ops_busy, stat_rd_done, cfg_start_ff, stat_rd_start_ff, update_ff;
	logic busy_ff, status_valid_flag_ff, global_load_enable_ff;
	logic [2:0] mode_ff;
	qdcc_cfg_t cfg_ff;
	qdcc_irq_t irq_ff;
	int err_count = 0;
	int tests_run = 0;
	int n;
	logic [31:0] ut_ctl [6] = '{32'h0, 32'h1, 32'h1, 32'h101, 32'h101, 32'h3};
	logic [7:0] ut_ev [6] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h02, 8'h08};
	logic ut_exp [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

	always #25 clk_sys = ~clk_sys;

	// short auto-read delay keeps the run brief
	qdcc_regs #(.DELAY_CYC(5)) qdcc_regs_i (.clk_sys, .rstn, .lb_cs, .lb_wr, .lb_rd, .lb_addr,
		.lb_wdata, .lb_rdata_ff, .lb_ack_ff, .conv_ops_busy, .stat_rd_done,
		.chan_xfer_done(ev[0]), .own_xfer_done(ev[1]), .glob_xfer_done(ev[2]),
		.seq_update(ev[3]), .auto_tmr_tick(ev[4]), .irq_src(qdcc_irq_t'(ev[7:5])), .cfg_ff,
		.cfg_start_ff, .stat_rd_start_ff, .update_ff, .busy_ff, .status_valid_flag_ff,
		.irq_ff, .mode_ff, .global_load_enable_ff);
	qdcc_conv_model qdcc_conv_model_i (.clk_sys, .rstn, .rd_go(cfg_start_ff | stat_rd_start_ff),
		.lat, .hold, .done(stat_rd_done), .link_busy(conv_ops_busy));

	////////////////////////////////////////////////////////////
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// register image of the stored configuration; reserved bit 12 shows as zero
	function automatic logic [31:0] cfg_word(input qdcc_cfg_t c);
		return {12'h000, c.pwrup, c.therm_ena, c.clamp_ena, c.clear_default_select, 1'b0, c.range_d,
			c.range_c, c.range_b, c.range_a};
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one bus access; strobe is a single cycle, answer lands one edge later
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		lb_cs <= 1'b1;
		lb_wr <= w;
		lb_rd <= !w;
		lb_addr <= a;
		lb_wdata <= d;
		@(posedge clk_sys);
		lb_cs <= 1'b0;
		lb_wr <= 1'b0;
		lb_rd <= 1'b0;
		#1;
		rv = lb_rdata_ff;
	endtask
	// pulse event inputs; the registered reaction stands for one cycle only,
	// so return just after the edge that takes the pulse
	task fire(input logic [7:0] v);
		@(posedge clk_sys);
		ev <= v;
		@(posedge clk_sys);
		ev <= 8'h00;
		#1;
	endtask
	task wait_rd;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (stat_rd_start_ff !== 1'b1 && n < 40);
	endtask
	task settle;
		n = 0;
		while ((busy_ff !== 1'b0 || status_valid_flag_ff !== 1'b1) && n < 60) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("settle", n < 60, 1);
	endtask

	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		acc(0, OFS_CONFIG, 0);
		chk("cfg reset", rv, 32'h0000_4000);
		chk("valid reset", status_valid_flag_ff, 0);
		acc(0, OFS_CONTROL, 0);
		chk("ctl reset", rv, 32'h0);
		acc(0, 8'h40, 0);
		chk("unmapped", rv, 32'h0);
		acc(1, OFS_CONFIG, 32'h000f_255c);
		chk("cfg", cfg_word(cfg_ff), 32'h000f_255c);
		acc(1, OFS_CONFIG, 32'h0);
		chk("busy ack", lb_ack_ff, 1);
		chk("busy drop", cfg_word(cfg_ff), 32'h000f_255c);
		settle;
		acc(0, OFS_CONFIG, 0);
		chk("cfg read", rv, 32'h000f_255c);
		lat <= 4'h1;
		for (int c = 0; c < 6; c++) begin
			acc(1, OFS_CONFIG, c * 32'h249);
			settle;
			acc(0, OFS_CONFIG, 0);
			chk("range", rv, c * 32'h249);
		end
		// request while the link is busy must wait, not vanish
		hold <= 1'b1;
		acc(1, OFS_CONTROL, 32'h200);
		chk("req clear", status_valid_flag_ff, 0);
		repeat (5) @(posedge clk_sys);
		chk("req held", status_valid_flag_ff, 0);
		hold <= 1'b0;
		settle;
		acc(0, OFS_CONTROL, 0);
		chk("req bit", rv, 32'h0);
		acc(1, OFS_CONTROL, 32'h3);
		acc(1, OFS_CONTROL, 32'h203);
		chk("timer req", status_valid_flag_ff, 1);
		for (int i = 0; i < 6; i++) begin
			acc(1, OFS_CONTROL, ut_ctl[i]);
			fire(ut_ev[i]);
			chk("update", update_ff, ut_exp[i]);
		end
		acc(1, OFS_CONTROL, 32'h83);
		fire(8'h08);
		wait_rd;
		chk("timer read", n >= 4 && n <= 9, 1);
		wait_rd;
		chk("timer once", n, 40);
		acc(1, OFS_CONTROL, 32'h81);
		fire(8'h10);
		wait_rd;
		chk("tick read", n < 6, 1);
		acc(1, OFS_CONTROL, 32'h01);
		fire(8'h10);
		wait_rd;
		chk("tick off", n, 40);
		for (int e = 0; e < 2; e++) begin
			acc(1, OFS_CONTROL, e ? 32'h11 : 32'h29);
			for (int b = 0; b < 3; b++) begin
				fire(8'h20 << b);
				chk("irq", irq_ff, ((e ? 3'h2 : 3'h5) & (3'h1 << b)));
			end
			chk("mode kept", mode_ff, 1);
		end
		give_verdict;
	end

	// cut a hang short
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		give_verdict;
	end
endmodule
